/* tscr_defs.vh */
// Notes on behaviour
// - Tile control bits 25:18 hold transmit data delay in PLL cycles, reset zero.
// - PLL-clocked counter drives transmit clock high at divider value, low at half.
// - Tile control bit 8 enables Ethernet peripheral ports, reset zero.
// - Bit 5 dynamic: divider acts only while all active threads are paused.
// - Tile control bit 4 enables low-power PLL clock division, reset zero.
// - Tile control bit 2 selects UTMI when one, ULPI when zero.
// - Tile control bit 1 enables the ULPI hardware support module.
// - Boot status is read-only: processor number 23:16, strap override bit 8.
// - Boot status bits 1:0 show the sampled boot PLL mode pins.
// - Boot status bit 3 means boot from RAM, bit 2 boot through JTAG.
// - Boot status bit 5 second core powered off, bit 4 skip read-level polling.
// - Once security bit 31 is set, further writes to that register are refused.
// - Security bit 14 blocks global debug, bit 0 blocks JTAG debug TAP.
// - Security bit 12 locks all sectors, 11:8 lock single sectors, 7 redundancy.
// - Security bit 5 overrides strapped boot mode, booting from one-time memory.
// - Security bit 4 blocks JTAG access to PLL and boot configuration.
// - Security register is loaded from the one-time programmable memory.
// - Four free-running ring oscillators each clock a counter, started and stopped here.
// - Control bit 1 enables core oscillators, bit 0 peripheral ones, reset zero.
// - Ring oscillators run asynchronously to the tile clock as random source.
`ifndef TSCR_DEFS_VH
`define TSCR_DEFS_VH
`define TSCR_REG_TILE_CTRL 8'h02
`define TSCR_REG_BOOT_STAT 8'h03
`define TSCR_REG_SEC_CFG 8'h05
`define TSCR_REG_RO_CTRL 8'h06
`define TSCR_RES_TYPE_PS 8'h0B
`define TSCR_TC_MASK 32'h03FF_FF36
`define TSCR_TC_RESET 32'h0000_0000
`define TSCR_SEC_MASK 32'h8000_5FB1
`define TSCR_RO_MASK 32'h0000_0003
`define TSCR_TC_DLY_HI 25
`define TSCR_TC_DLY_LO 18
`define TSCR_TC_DIV_HI 17
`define TSCR_TC_DIV_LO 9
`define TSCR_TC_ETH_EN 8
`define TSCR_TC_DYN 5
`define TSCR_TC_LP_EN 4
`define TSCR_TC_UTMI 2
`define TSCR_TC_ULPI_EN 1
`define TSCR_SEC_WLOCK 31
`define TSCR_SEC_GDBG_DIS 14
`define TSCR_SEC_LOCK_ALL 12
`define TSCR_SEC_LOCK_HI 11
`define TSCR_SEC_LOCK_LO 8
`define TSCR_SEC_REDUND 7
`define TSCR_SEC_OTP_BOOT 5
`define TSCR_SEC_JCFG_DIS 4
`define TSCR_SEC_TAP_DIS 0
`define TSCR_RO_CORE 1
`define TSCR_RO_PERIPH 0
`define TSCR_STOP_SETTLE 10
`endif

/* tscr_txclk_gen.v */
`include "tscr_defs.vh"

module tscr_txclk_gen (
	input wire core_clk, // Core clock (PLL derived).
	input wire rst_n, // Synchronous reset, active low.
	input wire enable, // Ethernet ports enabled.
	input wire [8:0] divVal, // Divider value, ratio minus one.
	output reg txClk_q // Transmit clock output.
);
	reg [8:0] cnt_q;
	wire [8:0] halfVal = {1'b0, divVal[8:1]};

	always @(posedge core_clk) begin
		if (!rst_n || !enable) begin
			cnt_q <= 9'h000;
			txClk_q <= 1'b0;
		end else begin
			cnt_q <= (cnt_q >= divVal) ? 9'h000 : cnt_q + 9'h001;
			if (cnt_q == divVal) begin
				txClk_q <= 1'b1;
			end else if (cnt_q == halfVal) begin
				txClk_q <= 1'b0;
			end
		end
	end
endmodule // tscr_txclk_gen

/* tscr_tile_regs.v */
`include "tscr_defs.vh"

module tscr_tile_regs (
	input wire core_clk, // Core clock.
	input wire rst_n, // Synchronous reset, active low.
	input wire psWrite, // Status write strobe.
	input wire psRead, // Status read strobe.
	input wire [15:0] psResId, // Resource identifier.
	input wire [31:0] psWdata, // Write data.
	output reg [31:0] psRdata_q, // Read data.
	output reg psRdValid_q, // Read data valid pulse.
	input wire [31:0] otpSecWord, // Security word from one-time memory.
	input wire otpLoad, // Load pulse for security word.
	input wire [7:0] procNum, // Processor number.
	input wire [1:0] bootPllPins, // Boot PLL mode pins.
	input wire bootFromRam, // Boot from RAM flag.
	input wire bootFromJtag, // Boot through JTAG flag.
	input wire core1Off, // Second core powered off.
	input wire skipOtpPoll, // Skip read-level polling.
	input wire allThreadsPaused, // Every active thread paused.
	output reg [7:0] txDataDelay_q, // Transmit data delay.
	output reg txClk_q, // Transmit clock.
	output reg ethPortsEn_q, // Ethernet ports enable.
	output reg lpDivActive_q, // Low-power divider active.
	output reg utmiSel_q, // UTMI selected, ULPI when low.
	output reg ulpiEn_q, // ULPI support enable.
	output reg globalDbgDis_q, // Global debug blocked.
	output reg tapDis_q, // JTAG debug TAP blocked.
	output reg [3:0] otpSectorLock_q, // Effective sector locks.
	output reg otpRedundEn_q, // One-time memory redundancy.
	output reg otpBootOverride_q, // Boot image from one-time memory.
	output reg jtagCfgDis_q, // JTAG config access blocked.
	output reg coreRoscEn_q, // Core ring oscillators enable.
	output reg periphRoscEn_q // Peripheral ring oscillators enable.
);
	reg [31:0] tileCtrl_q;
	reg [31:0] secCfg_q;
	reg [31:0] roCtrl_q;
	reg [1:0] pllMeta_q;
	reg [1:0] pllSync_q;
	reg [31:0] rdMux;
	wire txClkInt;

	function isReg;
		input [15:0] id;
		input [7:0] num;
		begin
			isReg = (id == {num, `TSCR_RES_TYPE_PS});
		end
	endfunction

	wire wrTile = psWrite && isReg(psResId, `TSCR_REG_TILE_CTRL);
	wire wrSec = psWrite && isReg(psResId, `TSCR_REG_SEC_CFG);
	wire wrRo = psWrite && isReg(psResId, `TSCR_REG_RO_CTRL);

	// Pins are asynchronous, so two flip-flops precede any use.
	always @(posedge core_clk) begin
		if (!rst_n) begin
			pllMeta_q <= 2'h0;
			pllSync_q <= 2'h0;
		end else begin
			pllMeta_q <= bootPllPins;
			pllSync_q <= pllMeta_q;
		end
	end

	always @(posedge core_clk) begin
		if (!rst_n) begin
			tileCtrl_q <= `TSCR_TC_RESET;
			secCfg_q <= 32'h0000_0000;
			roCtrl_q <= 32'h0000_0000;
		end else begin
			if (wrTile) begin
				tileCtrl_q <= psWdata & `TSCR_TC_MASK;
			end
			if (otpLoad) begin
				secCfg_q <= otpSecWord & `TSCR_SEC_MASK;
			end else if (wrSec && !secCfg_q[`TSCR_SEC_WLOCK]) begin
				secCfg_q <= psWdata & `TSCR_SEC_MASK;
			end
			if (wrRo) begin
				roCtrl_q <= psWdata & `TSCR_RO_MASK;
			end
		end
	end

	always @* begin
		rdMux = 32'h0000_0000;
		if (isReg(psResId, `TSCR_REG_TILE_CTRL)) begin
			rdMux = tileCtrl_q;
		end else if (isReg(psResId, `TSCR_REG_BOOT_STAT)) begin
			// Strap override mirrors the security override bit.
			rdMux = {8'h00, procNum, 7'h00, secCfg_q[`TSCR_SEC_OTP_BOOT], 2'h0, core1Off, skipOtpPoll,
				bootFromRam, bootFromJtag, pllSync_q};
		end else if (isReg(psResId, `TSCR_REG_SEC_CFG)) begin
			rdMux = secCfg_q;
		end else if (isReg(psResId, `TSCR_REG_RO_CTRL)) begin
			rdMux = roCtrl_q;
		end
	end

	always @(posedge core_clk) begin
		if (!rst_n) begin
			psRdata_q <= 32'h0000_0000;
			psRdValid_q <= 1'b0;
		end else begin
			psRdValid_q <= psRead;
			if (psRead) begin
				psRdata_q <= rdMux;
			end
		end
	end

	always @(posedge core_clk) begin
		if (!rst_n) begin
			txDataDelay_q <= 8'h00;
			ethPortsEn_q <= 1'b0;
			lpDivActive_q <= 1'b0;
			utmiSel_q <= 1'b0;
			ulpiEn_q <= 1'b0;
			globalDbgDis_q <= 1'b0;
			tapDis_q <= 1'b0;
			otpSectorLock_q <= 4'h0;
			otpRedundEn_q <= 1'b0;
			otpBootOverride_q <= 1'b0;
			jtagCfgDis_q <= 1'b0;
			coreRoscEn_q <= 1'b0;
			periphRoscEn_q <= 1'b0;
			txClk_q <= 1'b0;
		end else begin
			txDataDelay_q <= tileCtrl_q[`TSCR_TC_DLY_HI:`TSCR_TC_DLY_LO];
			ethPortsEn_q <= tileCtrl_q[`TSCR_TC_ETH_EN];
			lpDivActive_q <= tileCtrl_q[`TSCR_TC_LP_EN]
				&& (!tileCtrl_q[`TSCR_TC_DYN] || allThreadsPaused);
			utmiSel_q <= tileCtrl_q[`TSCR_TC_UTMI];
			ulpiEn_q <= tileCtrl_q[`TSCR_TC_ULPI_EN];
			globalDbgDis_q <= secCfg_q[`TSCR_SEC_GDBG_DIS];
			tapDis_q <= secCfg_q[`TSCR_SEC_TAP_DIS];
			otpSectorLock_q <= secCfg_q[`TSCR_SEC_LOCK_HI:`TSCR_SEC_LOCK_LO]
				| {4{secCfg_q[`TSCR_SEC_LOCK_ALL]}};
			otpRedundEn_q <= secCfg_q[`TSCR_SEC_REDUND];
			otpBootOverride_q <= secCfg_q[`TSCR_SEC_OTP_BOOT];
			jtagCfgDis_q <= secCfg_q[`TSCR_SEC_JCFG_DIS];
			// Oscillators and counters sit outside; these enables start them.
			coreRoscEn_q <= roCtrl_q[`TSCR_RO_CORE];
			periphRoscEn_q <= roCtrl_q[`TSCR_RO_PERIPH];
			txClk_q <= txClkInt;
		end
	end

	tscr_txclk_gen uTxClk (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.enable(tileCtrl_q[`TSCR_TC_ETH_EN]),
		.divVal(tileCtrl_q[`TSCR_TC_DIV_HI:`TSCR_TC_DIV_LO]),
		.txClk_q(txClkInt)
	);
endmodule // tscr_tile_regs

/* tscr_regs_chk.sv */
module tscr_regs_chk (
	input wire core_clk, // Clock.
	input wire rst_n, // Reset.
	input wire psWrite, // Write strobe.
	input wire psRead, // Read strobe.
	input wire [15:0] psResId, // Resource id.
	input wire [31:0] psWdata, // Write data.
	input wire [31:0] psRdata_q, // Read data.
	input wire psRdValid_q, // Read valid.
	input wire [31:0] otpSecWord, // Security word.
	input wire otpLoad, // Security load.
	input wire [7:0] txDataDelay_q, // Data delay.
	input wire ethPortsEn_q, // Port enable.
	input wire utmiSel_q, // Usb select.
	input wire tapDis_q, // Tap block.
	input wire coreRoscEn_q // Core oscillators.
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	sequence tileWr;
		psWrite && psResId == 16'h020B;
	endsequence
	sequence oscWr;
		psWrite && psResId == 16'h060B;
	endsequence
	read_valid_a: assert property (psRead |=> psRdValid_q) else $error("read valid missing");
	data_delay_a: assert property (tileWr |=> ##1 txDataDelay_q == $past(psWdata[25:18], 2)) else $error("delay");
	eth_enable_a: assert property (tileWr |=> ##1 ethPortsEn_q == $past(psWdata[8], 2)) else $error("eth");
	usb_select_a: assert property (tileWr |=> ##1 utmiSel_q == $past(psWdata[2], 2)) else $error("usb");
	osc_enable_a: assert property (oscWr |=> ##1 coreRoscEn_q == $past(psWdata[1], 2)) else $error("osc");
	otp_load_a: assert property (otpLoad |=> ##1 tapDis_q == $past(otpSecWord[0], 2)) else $error("otp");
	unmapped_zero_a: assert property (psRead && psResId == 16'h040B |=> psRdata_q == 32'h0) else $error("gap");
	osc_reserved_a: assert property (psRead && psResId == 16'h060B |=> psRdata_q[31:2] == 30'h0) else $error("rsv");
endmodule // tscr_regs_chk

bind tscr_tile_regs tscr_regs_chk u_chk (.core_clk, .rst_n, .psWrite, .psRead, .psResId, .psWdata, .psRdata_q,
	.psRdValid_q, .otpSecWord, .otpLoad, .txDataDelay_q, .ethPortsEn_q, .utmiSel_q, .tapDis_q, .coreRoscEn_q);

/* tb_top.sv */
module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic core_clk = 0, rst_n = 0, psWrite = 0, psRead = 0, otpLoad = 0, allThreadsPaused = 0;
	logic [15:0] psResId = 16'h0000;
	logic [31:0] psWdata = 32'h0, otpSecWord = 32'h0, tc = 32'h0, sec = 32'h0, ro = 32'h0, r, seed = 32'hCBE8;
	logic [7:0] procNum = 8'h00;
	logic [5:0] straps = 6'h00;
	logic [22:0] ev;
	wire [31:0] psRdata_q;
	wire [7:0] txDataDelay_q;
	wire [3:0] otpSectorLock_q;
	wire psRdValid_q, ethPortsEn_q, lpDivActive_q, utmiSel_q, ulpiEn_q, globalDbgDis_q, tapDis_q;
	wire otpRedundEn_q, otpBootOverride_q, jtagCfgDis_q, coreRoscEn_q, periphRoscEn_q;
	wire txClk_q;
	integer mCnt = 0;
	logic mClk = 0, mTx = 0;
	wire [22:0] outv = {txDataDelay_q, ethPortsEn_q, lpDivActive_q, utmiSel_q, ulpiEn_q, globalDbgDis_q, tapDis_q,
		otpSectorLock_q, otpRedundEn_q, otpBootOverride_q, jtagCfgDis_q, coreRoscEn_q, periphRoscEn_q};
	integer fails = 0, num_checks = 0;
	tscr_tile_regs u_dut (.core_clk, .rst_n, .psWrite, .psRead, .psResId, .psWdata, .psRdata_q, .psRdValid_q,
		.otpSecWord, .otpLoad, .procNum, .bootPllPins(straps[1:0]), .bootFromRam(straps[3]), .bootFromJtag(straps[2]),
		.core1Off(straps[5]), .skipOtpPoll(straps[4]), .allThreadsPaused, .txDataDelay_q, .txClk_q, .ethPortsEn_q,
		.lpDivActive_q, .utmiSel_q, .ulpiEn_q, .globalDbgDis_q, .tapDis_q, .otpSectorLock_q, .otpRedundEn_q,
		.otpBootOverride_q, .jtagCfgDis_q, .coreRoscEn_q, .periphRoscEn_q);
	initial forever #50 core_clk = ~core_clk;
	function automatic logic [31:0] xs();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		num_checks++;
		if (g !== e) begin
			fails++;
			$display("wrong value at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	// Transmit clock reference: the counter wraps at the divider value and one output flop follows.
	always @(posedge core_clk) begin
		mTx = rst_n ? mClk : 1'b0;
		if (!rst_n || !tc[8]) begin
			mCnt = 0;
			mClk = 0;
		end else begin
			if (mCnt == tc[17:9]) mClk = 1;
			else if (mCnt == (tc[17:9] >> 1)) mClk = 0;
			mCnt = (mCnt >= tc[17:9]) ? 0 : mCnt + 1;
		end
	end
	always @(negedge core_clk) chk({31'h0, txClk_q}, {31'h0, mTx});
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(negedge core_clk);
		psWrite = 1;
		psResId = {a, 8'h0B};
		psWdata = d;
		@(negedge core_clk);
		psWrite = 0;
		if (a == 8'h02) tc = d & 32'h03FFFF36;
		if (a == 8'h05 && !sec[31]) sec = d & 32'h80005FB1;
		if (a == 8'h06) ro = d & 32'h3;
	endtask
	task automatic rd(input logic [7:0] a);
		logic [31:0] e;
		e = a == 8'h02 ? tc : a == 8'h05 ? sec : a == 8'h06 ? ro : 32'h0;
		if (a == 8'h03) e = {8'h00, procNum, 7'h00, sec[5], 2'b00, straps};
		@(negedge core_clk);
		psRead = 1;
		psResId = {a, 8'h0B};
		@(negedge core_clk);
		psRead = 0;
		chk({31'h0, psRdValid_q}, 32'h1);
		chk(psRdata_q, e);
	endtask
	task automatic outs;
		repeat (2) @(negedge core_clk);
		ev = {tc[25:18], tc[8], tc[4] & (!tc[5] | allThreadsPaused), tc[2], tc[1], sec[14], sec[0],
			sec[11:8] | {4{sec[12]}}, sec[7], sec[5], sec[4], ro[1], ro[0]};
		chk({9'h0, outv}, {9'h0, ev});
	endtask
	task automatic finish_test;
		$display("checks %0d mismatches %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	initial begin
		#1000000;
		fails++;
		finish_test;
	end
	initial begin
		repeat (3) @(posedge core_clk);
		@(negedge core_clk);
		rst_n = 1;
		outs;
		for (int i = 0; i < 8; i++) rd(i[7:0]);
		wr(8'h02, 32'h0000_0700);
		repeat (12) @(negedge core_clk);
		wr(8'h02, 32'h0000_0B00);
		repeat (14) @(negedge core_clk);
		wr(8'h06, 32'h0000_0003);
		wr(8'h06, 32'h0000_0000);
		repeat (10) @(negedge core_clk);
		rd(8'h06);
		for (int n = 0; n < 300; n++) begin
			r = xs();
			{allThreadsPaused, straps, procNum} = r[14:0];
			if (n == 150) begin
				rst_n = 0;
				repeat (3) @(negedge core_clk);
				rst_n = 1;
				tc = 32'h0;
				sec = 32'h0;
				ro = 32'h0;
				outs;
			end
			repeat (3) @(negedge core_clk);
			case (r[18:16])
				3'h0, 3'h1: wr(8'h02, xs());
				3'h2: wr(8'h05, xs());
				3'h3: wr(8'h06, xs());
				3'h4: wr({5'h00, r[21:19]} | 8'h04, xs());
				3'h5: begin
					otpSecWord = xs();
					otpLoad = 1;
					@(negedge core_clk);
					otpLoad = 0;
					sec = otpSecWord & 32'h80005FB1;
				end
				default: rd({5'h00, r[21:19]});
			endcase
			outs;
			rd(r[31] ? 8'h03 : 8'h05);
		end
		finish_test;
	end
endmodule // tb_top
